/* File: hdl/wdt_pkg.sv */
// package: register map, field layout, reset values and rate codes of the watchdog block
package wdt_pkg;

    // register byte addresses; 0x2B is not word aligned, so both are kept as indices
    localparam logic [7:0]  SETUP_IDX          = 8'h00;
    localparam logic [7:0]  COUNTDOWN_IDX      = 8'h2B;
    localparam logic [11:0] SETUP_ADDR         = {2'b00, SETUP_IDX, 2'b00};
    localparam logic [11:0] COUNTDOWN_ADDR     = {2'b00, COUNTDOWN_IDX, 2'b00};
    localparam logic [11:0] STATUS_ADDR        = 12'h0B0;

    // engine_setup field positions
    localparam int SYNC_EN_BIT    = 0;
    localparam int BOOT_SRC_BIT   = 1;
    localparam int LOW_POWER_BIT  = 2;
    localparam int MOD_RATE_BIT   = 3;
    localparam int MCLK_EN_BIT    = 4;
    localparam int MCLK2_EN_BIT   = 5;
    localparam int MCLK_SEL_LSB   = 8;
    localparam int WD_SEL_LSB     = 12;
    localparam int ENG_SEL_LSB    = 16;

    localparam logic [23:0] SETUP_RESET     = 24'h050401;
    localparam logic [23:0] SETUP_WR_MASK   = 24'h07773D;
    localparam logic [15:0] COUNT_RESET     = 16'h0000;

    // rate codes shared by the engine and countdown clock selects
    typedef enum logic [2:0] {
        RATE_32K  = 3'b000,
        RATE_256K = 3'b001,
        RATE_512K = 3'b010,
        RATE_1M   = 3'b011,
        RATE_2M   = 3'b100,
        RATE_4M   = 3'b101,
        RATE_8M   = 3'b110,
        RATE_RSVD = 3'b111
    } wdt_rate_t;

    localparam int CLOCK_HZ = 50000000;

    // reset pulse width handed to the chip reset logic
    localparam int RESET_PULSE_NS     = 1000;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;

endpackage

/* File: hdl/wdt_tick_gen.sv */
// tick generator: one pulse per period of the selected countdown clock rate
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_gen
    import wdt_pkg::*;
#(
    parameter int CLK_HZ = CLOCK_HZ
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [2:0] rate_sel,
    output logic            tick
);

    // phase accumulator: rates are not integer divisors of the system clock
    function automatic logic [31:0] rate_hz(input logic [2:0] code);
        case (code)
            RATE_256K: rate_hz = 32'd256000;
            RATE_512K: rate_hz = 32'd512000;
            RATE_1M:   rate_hz = 32'd1024000;
            RATE_2M:   rate_hz = 32'd2048000;
            RATE_4M:   rate_hz = 32'd4096000;
            RATE_8M:   rate_hz = 32'd8192000;
            RATE_32K:  rate_hz = 32'd32000;
            default:   rate_hz = 32'd0;
        endcase
    endfunction

    logic [31:0] acc_q;
    logic [32:0] sum;
    logic        wrap;

    assign sum  = {1'b0, acc_q} + {1'b0, rate_hz(rate_sel)};
    assign wrap = (sum >= 33'(CLK_HZ));

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= 32'h0000_0000;
            tick  <= 1'b0;
        end else begin
            acc_q <= wrap ? 32'(sum - 33'(CLK_HZ)) : sum[31:0];
            tick  <= wrap;
        end
    end

endmodule
`default_nettype wire

/* File: hdl/wdt_reset_timer.sv */
// watchdog reset timer with engine setup register, AXI4-Lite slave
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module wdt_reset_timer
    import wdt_pkg::*;
#(
    parameter int RST_CYCLES = RESET_PULSE_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // axi4-lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // decimation engine side
    input  wire logic        engine_restart,
    input  wire logic        burst_active,
    input  wire logic        boot_strap,
    input  wire logic        sync_in,
    // outputs
    output logic             modulator_sync_out,
    output logic             watchdog_reset,
    output logic             reboot_from_prom,
    output logic             reboot_from_host,
    output logic             low_power_hold,
    output logic             modulator_input_rate_select,
    output logic             master_clock_out_enable,
    output logic             half_master_clock_out_enable,
    output logic [2:0]       master_clock_out_select,
    output logic [2:0]       engine_clock_select
);

    // pin synchronisers
    logic [1:0] strap_sync_q;
    logic [1:0] sync_in_q;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            strap_sync_q <= 2'b00;
            sync_in_q    <= 2'b00;
        end else begin
            strap_sync_q <= {strap_sync_q[0], boot_strap};
            sync_in_q    <= {sync_in_q[0], sync_in};
        end
    end

    // ---------------- axi4-lite write path ----------------
    logic        aw_held_q;
    logic        w_held_q;
    logic [11:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        wr_fire;
    logic        setup_hit_w;
    logic        count_hit_w;

    assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
    assign wr_fire       = aw_held_q && w_held_q && !s_axi_bvalid;
    assign setup_hit_w   = (awaddr_q[11:2] == SETUP_ADDR[11:2]);
    assign count_hit_w   = (awaddr_q[11:2] == COUNTDOWN_ADDR[11:2]);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 12'h000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (setup_hit_w || count_hit_w) ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        merge = old;
        for (int i = 0; i < 3; i++) begin
            if (be[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    // ---------------- engine_setup register ----------------
    logic [23:0] setup_q;
    logic [23:0] setup_d;
    logic        wd_reset_q;
    logic        mclk_code_ok;

    assign setup_d = merge(setup_q, wdata_q, wstrb_q) & SETUP_WR_MASK;
    assign mclk_code_ok = setup_d[MCLK_SEL_LSB +: 3] inside {RATE_512K, RATE_1M,
                                                               RATE_2M, RATE_4M};

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            setup_q <= SETUP_RESET & SETUP_WR_MASK;
        end else if (wd_reset_q) begin
            setup_q <= SETUP_RESET & SETUP_WR_MASK;
        end else if (wr_fire && setup_hit_w) begin
            setup_q <= setup_d;
            if (!mclk_code_ok) begin
                setup_q[MCLK_SEL_LSB +: 3] <= setup_q[MCLK_SEL_LSB +: 3];
            end
        end
    end

    wdt_rate_t wd_rate;
    assign wd_rate = wdt_rate_t'(setup_q[WD_SEL_LSB +: 3]);

    assign engine_clock_select          = setup_q[ENG_SEL_LSB +: 3];
    assign master_clock_out_select      = setup_q[MCLK_SEL_LSB +: 3];
    assign low_power_hold               = setup_q[LOW_POWER_BIT];
    assign modulator_input_rate_select  = setup_q[MOD_RATE_BIT];
    assign master_clock_out_enable      = setup_q[MCLK_EN_BIT];
    assign half_master_clock_out_enable = setup_q[MCLK2_EN_BIT];

    // sync output is registered and gated by its enable
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            modulator_sync_out <= 1'b0;
        end else begin
            modulator_sync_out <= setup_q[SYNC_EN_BIT] & sync_in_q[1];
        end
    end

    // ---------------- countdown ----------------
    typedef enum logic [1:0] {
        WD_IDLE  = 2'b00,
        WD_RUN   = 2'b01,
        WD_FIRE  = 2'b10
    } wdt_state_t;

    wdt_state_t  state_q;
    logic [15:0] reload_q;
    logic [15:0] count_q;
    logic [15:0] rst_cnt_q;
    logic        tick;
    logic        count_wr;
    logic        restart_ok;

    assign count_wr   = wr_fire && count_hit_w && !wd_reset_q;
    // reloads are held off while a burst transfer is in progress
    assign restart_ok = engine_restart && !burst_active;
    logic [23:0] count_merged;
    assign count_merged = merge({8'h00, reload_q}, wdata_q, wstrb_q);

    wdt_tick_gen #(
        .CLK_HZ   (CLOCK_HZ)
    ) u_tick (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .rate_sel (wd_rate),
        .tick     (tick)
    );

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reload_q <= COUNT_RESET;
        end else if (wd_reset_q) begin
            reload_q <= COUNT_RESET;
        end else if (count_wr) begin
            reload_q <= count_merged[15:0];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= WD_IDLE;
            count_q   <= COUNT_RESET;
            rst_cnt_q <= 16'h0000;
        end else begin
            case (state_q)
                WD_IDLE: begin
                    if (count_wr) begin
                        // start at the written value, no enable bit needed
                        state_q <= WD_RUN;
                        count_q <= count_merged[15:0];
                    end
                end
                WD_RUN: begin
                    // further writes load the count as well as the reload; nothing stops the timer
                    if (count_wr) begin
                        count_q <= count_merged[15:0];
                    end else if (restart_ok) begin
                        count_q <= reload_q;
                    end else if (count_q == 16'h0000) begin
                        state_q   <= WD_FIRE;
                        rst_cnt_q <= 16'(RST_CYCLES);
                    end else if (tick) begin
                        count_q <= count_q - 16'h0001;
                    end
                end
                WD_FIRE: begin
                    if (rst_cnt_q <= 16'h0001) begin
                        state_q <= WD_IDLE;
                        count_q <= COUNT_RESET;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 16'h0001;
                    end
                end
                default: begin
                    state_q <= WD_IDLE;
                end
            endcase
        end
    end

    assign wd_reset_q     = (state_q == WD_FIRE);
    assign watchdog_reset = wd_reset_q;
    // boot path of the reset follows the strapped source
    assign reboot_from_prom = wd_reset_q && strap_sync_q[1];
    assign reboot_from_host = wd_reset_q && !strap_sync_q[1];

    // ---------------- axi4-lite read path ----------------
    logic [23:0] setup_rd;
    assign setup_rd = {setup_q[23:2], strap_sync_q[1], setup_q[0]};

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr[11:2])
                SETUP_ADDR[11:2]:     s_axi_rdata <= {8'h00, setup_rd};
                COUNTDOWN_ADDR[11:2]: s_axi_rdata <= {16'h0000, reload_q};
                STATUS_ADDR[11:2]:    s_axi_rdata <= {14'h0000, state_q, count_q};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---------------- assertions ----------------
    a_expiry_fires: assert property (@(posedge clock) disable iff (sys_rst)
        (state_q == WD_RUN && count_q == 16'h0000 && !count_wr && !restart_ok)
        |=> watchdog_reset) else $error("expiry did not fire reset");

    a_boot_route: assert property (@(posedge clock) disable iff (sys_rst)
        watchdog_reset |-> (reboot_from_prom != reboot_from_host))
        else $error("reboot path not unique");

    a_write_starts: assert property (@(posedge clock) disable iff (sys_rst)
        (state_q == WD_IDLE && count_wr) |=> state_q == WD_RUN)
        else $error("count write did not start timer");

    a_no_sw_stop: assert property (@(posedge clock) disable iff (sys_rst)
        (state_q == WD_RUN) |=> state_q != WD_IDLE)
        else $error("running watchdog stopped without reset");

    a_tick_decrement: assert property (@(posedge clock) disable iff (sys_rst)
        (state_q == WD_RUN && tick && !count_wr && !restart_ok && count_q != 16'h0000)
        |=> count_q == $past(count_q) - 16'h0001)
        else $error("countdown did not decrement");

    a_burst_block: assert property (@(posedge clock) disable iff (sys_rst)
        (state_q == WD_RUN && burst_active && !count_wr && !tick && count_q != 16'h0000)
        |=> count_q == $past(count_q)) else $error("reload during burst");

    a_restart_reload: assert property (@(posedge clock) disable iff (sys_rst)
        (state_q == WD_RUN && restart_ok && !count_wr) |=> count_q == $past(reload_q))
        else $error("restart did not reload");

    a_sync_gate: assert property (@(posedge clock) disable iff (sys_rst)
        !setup_q[SYNC_EN_BIT] |=> !modulator_sync_out)
        else $error("sync out not held low");

    a_boot_bit: assert property (@(posedge clock) disable iff (sys_rst)
        setup_rd[BOOT_SRC_BIT] == strap_sync_q[1])
        else $error("boot bit not following strap");

endmodule
`default_nettype wire

/* File: tb/wdt_engine_model.sv */
// engine-side partner: periodic countdown restarts and a burst level
`timescale 1ns/1ps
`default_nettype none
module wdt_engine_model (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       run,
    input  wire logic       burst,
    input  wire logic [7:0] period,
    output logic            engine_restart,
    output logic            burst_active
);
    logic [7:0] cnt_q;

    // one pulse per finished filter pass; a shorter period models a faster engine
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q          <= 8'h00;
            engine_restart <= 1'b0;
        end else if (!run) begin
            cnt_q          <= 8'h00;
            engine_restart <= 1'b0;
        end else begin
            cnt_q          <= (cnt_q >= period) ? 8'h00 : cnt_q + 8'h01;
            engine_restart <= (cnt_q >= period);
        end
    end

    // pulses keep coming during a burst: the block itself must ignore them
    assign burst_active = burst;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the watchdog reset timer
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) \
    begin \
        samples_checked++; \
        if ((got) !== (exp)) begin \
            err_count++; \
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
        end \
    end
module testbench;
    import wdt_pkg::*;
    localparam int RST_N = 4;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [31:0] s_axi_rdata, rd_data;
    logic        boot_strap = 1'b0;
    logic        sync_in = 1'b1;
    logic        run = 1'b0;
    logic        burst = 1'b0;
    logic        engine_restart, burst_active, modulator_sync_out, watchdog_reset;
    logic        reboot_from_prom, reboot_from_host, low_power_hold;
    logic        modulator_input_rate_select, master_clock_out_enable;
    logic        half_master_clock_out_enable;
    logic [2:0]  master_clock_out_select, engine_clock_select;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    int          fire_cyc = 0;

    always #10 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    always @(posedge clock) if (watchdog_reset === 1'b1) fire_cyc <= fire_cyc + 1;

    wdt_reset_timer #(.RST_CYCLES(RST_N)) u_wdt_reset_timer (
        .clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .engine_restart, .burst_active,
        .boot_strap, .sync_in, .modulator_sync_out, .watchdog_reset, .reboot_from_prom,
        .reboot_from_host, .low_power_hold, .modulator_input_rate_select,
        .master_clock_out_enable, .half_master_clock_out_enable,
        .master_clock_out_select, .engine_clock_select
    );

    wdt_engine_model u_wdt_engine_model (
        .clock, .sys_rst, .run, .burst, .period(8'd20), .engine_restart, .burst_active
    );

    task automatic stop_test();
        if (err_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ready is combinational, so it is judged at the falling edge before the taking edge
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, aw_hs, w_hs;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clock);
            aw_hs = s_axi_awvalid && s_axi_awready;
            w_hs = s_axi_wvalid && s_axi_wready;
            @(posedge clock);
            if (aw_hs) s_axi_awvalid <= 1'b0;
            if (w_hs) s_axi_wvalid <= 1'b0;
            aw_ok = aw_ok | aw_hs;
            w_ok = w_ok | w_hs;
        end while (!(aw_ok && w_ok));
        do @(negedge clock); while (s_axi_bvalid !== 1'b1);
        wr_resp = s_axi_bresp;
        @(posedge clock);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [11:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clock); while (s_axi_arready !== 1'b1);
        @(posedge clock);
        s_axi_arvalid <= 1'b0;
        do @(negedge clock); while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        @(posedge clock);
        s_axi_rready <= 1'b0;
    endtask

    task automatic arm(input logic [2:0] rate, input logic [15:0] n);
        axi_wr(SETUP_ADDR, {8'h00, SETUP_RESET[23:15], rate, SETUP_RESET[11:0]});
        axi_wr(COUNTDOWN_ADDR, {16'h00FF, n});
    endtask

    task automatic regs();
        axi_rd(SETUP_ADDR);
        `CHK(rd_data, {8'h00, SETUP_RESET})
        `CHK({engine_clock_select, master_clock_out_select}, 6'b101100)
        axi_rd(COUNTDOWN_ADDR);
        `CHK(rd_data, 32'h0)
        axi_rd(12'h010);
        `CHK({rd_resp, rd_data}, {2'b10, 32'h0})
        axi_wr(12'h010, 32'h0);
        `CHK(wr_resp, 2'b10)
        // bit 1 written as one must not stick; lane 3 is ignored
        axi_wr(SETUP_ADDR, 32'hFF03623E);
        `CHK(wr_resp, 2'b00)
        repeat (5) @(negedge clock);
        axi_rd(SETUP_ADDR);
        `CHK(rd_data, 32'h0003623C)
        `CHK({engine_clock_select, master_clock_out_select}, 6'b011010)
        `CHK({half_master_clock_out_enable, master_clock_out_enable}, 2'b11)
        `CHK({modulator_input_rate_select, low_power_hold}, 2'b11)
        `CHK(modulator_sync_out, 1'b0)
        @(posedge clock);
        boot_strap <= 1'b1;
        axi_wr(SETUP_ADDR, {8'h00, SETUP_RESET});
        repeat (5) @(negedge clock);
        `CHK(modulator_sync_out, 1'b1)
        `CHK({modulator_input_rate_select, low_power_hold}, 2'b00)
        axi_rd(SETUP_ADDR);
        `CHK(rd_data, {8'h00, SETUP_RESET} | 32'h2)
        // master clock code 001 is unsupported: selection stays at 100
        axi_wr(SETUP_ADDR, 32'h00050101);
        axi_rd(SETUP_ADDR);
        `CHK(rd_data, {8'h00, SETUP_RESET} | 32'h2)
        @(posedge clock);
        sync_in <= 1'b0;
        repeat (5) @(negedge clock);
        `CHK(modulator_sync_out, 1'b0)
        @(posedge clock);
        sync_in <= 1'b1;
    endtask

    // delay window depends on the tick period of the chosen rate
    task automatic expire(input logic [2:0] rate, input logic [15:0] n, input int lo,
                          input int hi);
        int t0;
        int f0;
        f0 = fire_cyc;
        arm(rate, n);
        t0 = cyc;
        axi_rd(COUNTDOWN_ADDR);
        `CHK(rd_data, {16'h0000, n})
        axi_wr(SETUP_ADDR, {8'h00, SETUP_RESET[23:15], rate, SETUP_RESET[11:0]});
        while (watchdog_reset !== 1'b1 && cyc - t0 < 3000) @(negedge clock);
        `CHK((cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1)
        `CHK({reboot_from_prom, reboot_from_host}, {boot_strap, ~boot_strap})
        repeat (RST_N + 4) @(negedge clock);
        `CHK(fire_cyc - f0, RST_N)
        axi_rd(SETUP_ADDR);
        `CHK(rd_data, {8'h00, SETUP_RESET[23:2], boot_strap, SETUP_RESET[0]})
    endtask

    task automatic keep_alive();
        int f0;
        f0 = fire_cyc;
        @(posedge clock);
        run <= 1'b1;
        // eight fast ticks span a bit over two restart periods
        arm(3'b110, 16'h0008);
        repeat (300) @(negedge clock);
        `CHK(fire_cyc - f0, 0)
        @(posedge clock);
        run <= 1'b0;
        repeat (80) @(negedge clock);
        `CHK(fire_cyc - f0, RST_N)
        @(posedge clock);
        run <= 1'b1;
        burst <= 1'b1;
        arm(3'b110, 16'h0008);
        repeat (80) @(negedge clock);
        `CHK(fire_cyc - f0, 2 * RST_N)
        @(posedge clock);
        run <= 1'b0;
        burst <= 1'b0;
    endtask

    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        regs();
        expire(3'b110, 16'h0008, 40, 62);
        @(posedge clock);
        boot_strap <= 1'b0;
        expire(3'b101, 16'h0008, 80, 112);
        keep_alive();
        stop_test();
    end

    // sized well above the fewer than one thousand cycles the scenarios need
    initial begin
        repeat (60000) @(posedge clock);
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
